/* File: logic/sci_pkg.sv */
`default_nettype none
package sci_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_FLAGS   = 8'h00;
  localparam logic [7:0] OFF_ENABLES = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0C;
  localparam logic [7:0] OFF_WIDTH   = 8'h10;

  // implemented bit masks and reset values
  localparam logic [7:0] FLAG_MASK   = 8'hF6;
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CNT_LO  = 8'h00;
  localparam logic [2:0] RST_CNT_HI  = 3'h0;
  localparam logic [2:0] RST_WIDTH   = 3'h0;

  // field positions in the flag and enable registers
  localparam int unsigned POS_SHIFT_EMPTY = 7;
  localparam int unsigned POS_COUNT_ZERO  = 6;
  localparam int unsigned POS_SEL_START   = 5;
  localparam int unsigned POS_SEL_END     = 4;
  localparam int unsigned POS_RX_OVER     = 2;
  localparam int unsigned POS_TX_UNDER    = 1;

  // counter and word geometry
  localparam int unsigned CNT_W      = 14;
  localparam logic [2:0]  WIDTH_FULL = 3'h0;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;

  typedef struct packed {
    logic shifter_empty_flag;
    logic count_zero_flag;
    logic select_start_flag;
    logic select_end_flag;
    logic unused3;
    logic receive_overflow_flag;
    logic transmit_underflow_flag;
    logic unused0;
  } sci_evt_t;

  typedef struct packed {
    logic [2:0] high;
    logic [7:0] low;
    logic [2:0] width;
  } sci_count_regs_t;

  function automatic logic sci_hit(input logic [7:0] addr, input logic [7:0] off);
    sci_hit = (addr == off);
  endfunction : sci_hit

endpackage : sci_pkg
`default_nettype wire

/* File: logic/sci_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sci_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule : sci_sync2
`default_nettype wire

/* File: logic/sci_spi_counter_status.sv */
// What this block does
// (R1) master: word done, idle shifter sets flag
// (R2) counter reaching zero sets count-zero flag
// (R3) select inactive-to-active sets start flag
// (R4) select active-to-inactive sets end flag
// (R5) slave: word done, rx full, required: overflow
// (R6) slave start, tx empty, required: underflow
// (R7) one enable bit per flag position
// (R8) bit mode: low register is bits 10-3
// (R9) word mode: low register is bits 7-0
// (R10) bit mode: high register is bits 13-11
// (R11) word mode: high register is bits 10-8
// (R12) bit mode: width field is bits 2-0
// (R13) word mode: width is word length, 0=8
// (R14) software avoids counter writes while busy
// (R15) flags hardware set, software read/write/clear
// (R16) unimplemented bits read as zero
// (R17) bit mode: total is width plus 8*count
// (R18) request when flag and enable both set
// (R19) count-zero only on step one to zero
// (R20) select flags in master and slave, override
// (R21) decrement per bit or word, hold zero
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sci_spi_counter_status
  import sci_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              master_mode_i,
  input  wire logic              length_mode_i,
  input  wire logic              select_active_low_i,
  input  wire logic              select_override_i,
  input  wire logic              clock_idle_high_i,
  input  wire logic              next_ready_i,
  input  wire logic              receive_buffer_full_i,
  input  wire logic              transmit_buffer_empty_i,
  input  wire logic              receive_space_required_i,
  input  wire logic              transmit_data_required_i,
  input  wire logic              sck_pin_i,
  input  wire logic              select_pin_i,
  output logic                   module_status_request_o,
  output logic      [CNT_W-1:0]  transfer_count_o
);

  logic       rst_n;
  logic [1:0] pins_s;
  logic       sck_s;
  logic       sel_pin_s;

  sci_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (1'b1),
    .q_o     (rst_n)
  );

  // raw reset: pin levels already real on exit, so no false select edge
  sci_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({sck_pin_i, select_pin_i}),
    .q_o     (pins_s)
  );

  assign sck_s     = pins_s[1];
  assign sel_pin_s = pins_s[0];

  // link edge tracking
  logic       sck_q;
  logic       sck_d;
  logic       sel_q;
  logic       sel_d;
  logic [2:0] bit_idx_q;
  logic [2:0] bit_idx_d;
  logic       sel_act;
  logic       lead_edge;
  logic       trail_edge;
  logic       bit_evt;
  logic       word_done;
  logic       start_evt;
  logic       last_bit;
  logic [3:0] word_len;

  // counter state
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             mode_q;
  logic             mode_d;
  logic [CNT_W-1:0] cnt_src;
  logic             cnt_load;
  logic             cnt_dec;
  logic             zero_evt;

  // register file
  sci_evt_t        flags_q;
  sci_evt_t        flags_d;
  logic [7:0]      en_q;
  logic [7:0]      en_d;
  sci_count_regs_t cr_q;
  sci_count_regs_t cr_d;
  logic [31:0]     prdata_q;
  logic [31:0]     prdata_d;
  logic            pslverr_q;
  logic            pslverr_d;
  sci_evt_t        set_evt;
  logic            wr_en;
  logic [7:0]      addr8;
  logic            mapped;

  assign addr8 = 8'(paddr_i);
  assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];

  always_comb
  begin
    sel_act    = select_override_i || (select_active_low_i ? !sel_pin_s : sel_pin_s); // [R20]
    sck_d      = (sck_s != clock_idle_high_i); // active level; reset is idle either way
    lead_edge  = !sck_q && sck_d;
    trail_edge = sck_q && !sck_d;
    bit_evt    = trail_edge && (master_mode_i || sel_act);
    if (length_mode_i && cr_q.width != WIDTH_FULL)
      word_len = {1'b0, cr_q.width}; // [R13]
    else
      word_len = BYTE_BITS;
    // bit mode: last word is cut short when the counter empties
    last_bit  = ({1'b0, bit_idx_q} == word_len - 4'h1)
                || (!length_mode_i && cnt_q == CNT_W'(1)); // [R17]
    word_done = bit_evt && last_bit;
    start_evt = lead_edge && !master_mode_i && sel_act && (bit_idx_q == 3'h0);
    sel_d     = sel_act;
    if (word_done || (sel_q && !sel_act && !master_mode_i))
      bit_idx_d = 3'h0;
    else if (bit_evt)
      bit_idx_d = bit_idx_q + 3'h1;
    else
      bit_idx_d = bit_idx_q;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_q     <= 1'b0;
      sel_q     <= 1'b0;
      bit_idx_q <= 3'h0;
    end
    else
    begin
      sck_q     <= sck_d;
      sel_q     <= sel_d;
      bit_idx_q <= bit_idx_d;
    end
  end

  always_comb
  begin
    en_d   = en_q;
    cr_d   = cr_q;
    mapped = sci_hit(addr8, OFF_FLAGS) || sci_hit(addr8, OFF_ENABLES)
             || sci_hit(addr8, OFF_CNT_LO) || sci_hit(addr8, OFF_CNT_HI)
             || sci_hit(addr8, OFF_WIDTH);
    if (wr_en && sci_hit(addr8, OFF_ENABLES))
      en_d = pwdata_i[7:0] & FLAG_MASK; // [R7]
    if (wr_en && sci_hit(addr8, OFF_CNT_LO))
      cr_d.low = pwdata_i[7:0];
    if (wr_en && sci_hit(addr8, OFF_CNT_HI))
      cr_d.high = pwdata_i[2:0];
    if (wr_en && sci_hit(addr8, OFF_WIDTH))
      cr_d.width = pwdata_i[2:0];
    // read data captured in the setup cycle so prdata comes from a flop
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (psel_i && !penable_i)
    begin
      pslverr_d = !mapped;
      prdata_d  = 32'h0000_0000; // [R16]
      case (1'b1)
        sci_hit(addr8, OFF_FLAGS):   prdata_d[7:0] = flags_q & FLAG_MASK;
        sci_hit(addr8, OFF_ENABLES): prdata_d[7:0] = en_q;
        sci_hit(addr8, OFF_CNT_LO):  prdata_d[7:0] = cr_q.low;
        sci_hit(addr8, OFF_CNT_HI):  prdata_d[2:0] = cr_q.high;
        sci_hit(addr8, OFF_WIDTH):   prdata_d[2:0] = cr_q.width;
        default:                     prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q      <= RST_ENABLES;
      cr_q      <= {RST_CNT_HI, RST_CNT_LO, RST_WIDTH};
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      en_q      <= en_d;
      cr_q      <= cr_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q && psel_i && penable_i;
  assign pready_o  = psel_i && penable_i;

  // counter; a write while busy simply reloads, software must avoid it
  always_comb
  begin
    mode_d   = length_mode_i;
    if (mode_d)
      cnt_src = {3'h0, cr_d.high, cr_d.low}; // [R9] [R11]
    else
      cnt_src = {cr_d.high, cr_d.low, cr_d.width}; // [R8] [R10] [R12]
    cnt_load = (wr_en && (sci_hit(addr8, OFF_CNT_LO) || sci_hit(addr8, OFF_CNT_HI)
               || sci_hit(addr8, OFF_WIDTH))) || (mode_q != length_mode_i); // [R14]
    cnt_dec  = (cnt_q != '0) && (length_mode_i ? word_done : bit_evt); // [R21]
    zero_evt = cnt_dec && (cnt_q == CNT_W'(1)) && !cnt_load; // [R19]
    if (cnt_load)
      cnt_d = cnt_src;
    else if (cnt_dec)
      cnt_d = cnt_q - CNT_W'(1);
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= '0;
      mode_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      mode_q <= mode_d;
    end
  end

  assign transfer_count_o = cnt_q;

  // event flags: a hardware set in the same cycle as a clear wins
  always_comb
  begin
    set_evt                         = sci_evt_t'(8'h00);
    set_evt.shifter_empty_flag      = word_done && master_mode_i && !next_ready_i; // [R1]
    set_evt.count_zero_flag         = zero_evt; // [R2]
    set_evt.select_start_flag       = sel_act && !sel_q; // [R3]
    set_evt.select_end_flag         = !sel_act && sel_q; // [R4]
    set_evt.receive_overflow_flag   = word_done && !master_mode_i
                                      && receive_buffer_full_i && receive_space_required_i; // [R5]
    set_evt.transmit_underflow_flag = start_evt && transmit_buffer_empty_i
                                      && transmit_data_required_i; // [R6]
    flags_d = flags_q;
    if (wr_en && sci_hit(addr8, OFF_FLAGS))
      flags_d = sci_evt_t'(pwdata_i[7:0] & FLAG_MASK); // [R15]
    flags_d = sci_evt_t'((flags_d | set_evt) & FLAG_MASK); // [R15] [R16]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= sci_evt_t'(RST_FLAGS);
    else
      flags_q <= flags_d;
  end

  assign module_status_request_o = |(flags_q & en_q); // [R18]

  a_shift_empty_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R1]
    (bit_evt && last_bit && master_mode_i && !next_ready_i) |=> flags_q.shifter_empty_flag)
    else $error("shifter empty flag not set");

  a_count_zero_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R2]
    (cnt_dec && cnt_q == CNT_W'(1) && !cnt_load) |=> (cnt_q == '0) && flags_q.count_zero_flag)
    else $error("count zero flag not set on step to zero");

  a_sel_start_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R3]
    $rose(sel_q) |-> flags_q.select_start_flag)
    else $error("select start flag missing");

  a_sel_end_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R4]
    $fell(sel_q) |-> flags_q.select_end_flag)
    else $error("select end flag missing");

  a_rx_over_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R5]
    (word_done && !master_mode_i && receive_buffer_full_i && receive_space_required_i)
    |=> flags_q.receive_overflow_flag)
    else $error("receive overflow flag missing");

  a_tx_under_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    (start_evt && transmit_buffer_empty_i && transmit_data_required_i)
    |=> flags_q.transmit_underflow_flag)
    else $error("transmit underflow flag missing");

  a_request_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R18]
    (flags_q.count_zero_flag && en_q[POS_COUNT_ZERO]) |-> module_status_request_o)
    else $error("status request not raised");

  a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R16]
    (psel_i && !penable_i && (sci_hit(addr8, OFF_CNT_HI) || sci_hit(addr8, OFF_WIDTH)))
    |=> prdata_o[31:3] == 29'h0000_0000)
    else $error("unimplemented bits not zero");

  a_count_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R21]
    (cnt_q == '0 && !cnt_load) |=> cnt_q == '0)
    else $error("counter moved below zero");

  a_word_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R9] [R11]
    (cnt_load && length_mode_i) |=> cnt_q == {3'h0, cr_q.high, cr_q.low})
    else $error("word mode counter load wrong");

  a_bit_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R8] [R12]
    (cnt_load && !length_mode_i) |=> cnt_q == {cr_q.high, cr_q.low, cr_q.width})
    else $error("bit mode counter load wrong");

endmodule : sci_spi_counter_status
`default_nettype wire

/* File: sim/sci_spi_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module sci_spi_peer (
  output logic sck_o,
  output logic sel_o
);
  // clock stands at its idle level outside frames, never free-running
  task automatic frame(input int nbits);
    sel_o = 1'b0;
    #80;
    repeat (nbits)
    begin
      sck_o = 1'b1;
      #80;
      sck_o = 1'b0;
      #80;
    end
    sel_o = 1'b1;
    #160;
  endtask : frame

  initial
  begin
    sck_o = 1'b0;
    sel_o = 1'b1;
  end
endmodule : sci_spi_peer
`default_nettype wire

/* File: sim/sci_spi_counter_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module sci_spi_counter_status_test;
  import sci_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mst, lmode, ovr, nrdy, rxf, txe, receive_space_required, transmit_data_required;
  wire logic   sck;
  wire logic   sel;
  logic        req;
  logic [13:0] cnt;
  int          fail_count;
  int          n_compared;

  always #5 ref_clk = ~ref_clk;

  sci_spi_counter_status u_sci_spi_counter_status (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .master_mode_i(mst), .length_mode_i(lmode), .select_active_low_i(1'b1),
    .select_override_i(ovr), .clock_idle_high_i(1'b0), .next_ready_i(nrdy),
    .receive_buffer_full_i(rxf), .transmit_buffer_empty_i(txe),
    .receive_space_required_i(receive_space_required), .transmit_data_required_i(transmit_data_required),
    .sck_pin_i(sck), .select_pin_i(sel), .module_status_request_o(req),
    .transfer_count_o(cnt));

  sci_spi_peer u_sci_spi_peer (.sck_o(sck), .sel_o(sel));

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 8'h00, r, e);
    `CHK(r, {24'h000000, x})
    `CHK(e, xe)
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic cfg(input logic [7:0] v);
    @(posedge ref_clk);
    {mst, lmode, ovr, nrdy, rxf, txe, receive_space_required, transmit_data_required} <= v;
    idle(6);
  endtask : cfg

  // counter registers only written between frames
  task automatic load(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] w);
    wr(OFF_CNT_LO, lo);
    wr(OFF_CNT_HI, hi);
    wr(OFF_WIDTH, w);
    idle(2);
  endtask : load

  task automatic frame(input int n);
    u_sci_spi_peer.frame(n);
    idle(6);
  endtask : frame

  task automatic t_regs();
    rd(OFF_FLAGS, 8'h00, 1'b0);
    rd(OFF_ENABLES, 8'h00, 1'b0);
    rd(OFF_CNT_HI, 8'h00, 1'b0);
    rd(8'h14, 8'h00, 1'b1);
    wr(OFF_FLAGS, 8'hFF);
    wr(OFF_ENABLES, 8'hFF);
    load(8'hFF, 8'hFF, 8'hFF);
    rd(OFF_FLAGS, 8'hF6, 1'b0);
    rd(OFF_ENABLES, 8'hF6, 1'b0);
    rd(OFF_CNT_LO, 8'hFF, 1'b0);
    rd(OFF_CNT_HI, 8'h07, 1'b0);
    rd(OFF_WIDTH, 8'h07, 1'b0);
    `CHK(req, 1'b1)
    wr(OFF_FLAGS, 8'h00);
    idle(2);
    `CHK(req, 1'b0)
    load(8'h01, 8'h01, 8'h03);
    `CHK(cnt, 14'h080B)
    cfg(8'h40);
    load(8'h01, 8'h01, 8'h03);
    `CHK(cnt, 14'h0101)
    $display("registers and counter layout done");
  endtask : t_regs

  task automatic t_events();
    cfg(8'h00);
    wr(OFF_ENABLES, 8'h20);
    load(8'h04, 8'h00, 8'h00);
    frame(0);
    rd(OFF_FLAGS, 8'h30, 1'b0);
    `CHK(req, 1'b1)
    wr(OFF_FLAGS, 8'h00);
    cfg(8'h20);
    rd(OFF_FLAGS, 8'h20, 1'b0);
    cfg(8'h00);
    rd(OFF_FLAGS, 8'h30, 1'b0);
    wr(OFF_FLAGS, 8'h00);
    cfg(8'h0A);
    frame(8);
    rd(OFF_FLAGS, 8'h34, 1'b0);
    `CHK(cnt, 14'h0018)
    wr(OFF_FLAGS, 8'h00);
    cfg(8'h05);
    frame(8);
    rd(OFF_FLAGS, 8'h32, 1'b0);
    wr(OFF_FLAGS, 8'h00);
    cfg(8'h80);
    frame(8);
    rd(OFF_FLAGS, 8'hB0, 1'b0);
    `CHK(cnt, 14'h0008)
    wr(OFF_FLAGS, 8'h00);
    $display("event flags done");
  endtask : t_events

  task automatic t_zero();
    cfg(8'h00);
    wr(OFF_ENABLES, 8'h40);
    load(8'h00, 8'h00, 8'h03);
    `CHK(cnt, 14'h0003)
    frame(3);
    `CHK(cnt, 14'h0000)
    rd(OFF_FLAGS, 8'h70, 1'b0);
    `CHK(req, 1'b1)
    wr(OFF_FLAGS, 8'h00);
    cfg(8'h40);
    load(8'h02, 8'h00, 8'h02);
    frame(4);
    `CHK(cnt, 14'h0000)
    rd(OFF_FLAGS, 8'h70, 1'b0);
    wr(OFF_FLAGS, 8'h00);
    frame(2);
    `CHK(cnt, 14'h0000)
    rd(OFF_FLAGS, 8'h30, 1'b0);
    $display("count zero done");
  endtask : t_zero

  initial
  begin
    #300000;
    fail_count++;
    close_out();
  end

  initial
  begin
    ref_clk = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    {mst, lmode, ovr, nrdy, rxf, txe, receive_space_required, transmit_data_required} = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_events();
    t_zero();
    close_out();
  end
endmodule : sci_spi_counter_status_test
`default_nettype wire
